// ---- inc/dpcfg_defines.svh ----
// offsets, field positions, reset values of the datapath/doubler config group
// assumes an 8-bit register port decoded from the serial control interface
`ifndef DPCFG_DEFINES_SVH
`define DPCFG_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_RX_GAIN        8'h38
`define OFS_DBL_RST_TYPE   8'h39
`define OFS_TX_DBL_TUNE    8'h3A
`define OFS_RX_DBL_TUNE    8'h3B
`define OFS_DBL_TAP        8'h3C
`define OFS_SIGN_INV       8'h3D
`define OFS_DBL_PW         8'h3E
`define OFS_RX_IF_OPT      8'h3F

// ****************************************************************
// implemented-bit masks (unused bits read zero)
// ****************************************************************
`define MASK_RX_GAIN       8'h1F
`define MASK_DBL_RST_TYPE  8'hC3
`define MASK_FULL          8'hFF
`define MASK_SIGN_INV      8'h0F
`define MASK_DBL_PW        8'h3F
`define MASK_RX_IF_OPT     8'h7F

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_RX_DBL_RST     7
`define BIT_TX_DBL_RST     6
`define BIT_RX_DBL_TYPE    1
`define BIT_TX_DBL_TYPE    0
`define BIT_RX_Q_NEG       3
`define BIT_RX_I_NEG       2
`define BIT_TX_Q_NEG       1
`define BIT_TX_I_NEG       0
`define BIT_RX_CLK_I       6
`define BIT_RX_BUS_I       5
`define BIT_SINGLE_RX      4
`define BIT_TXPIN_DRIVE    3
`define BIT_HD_DIR_PIN     2
`define BIT_HD_CLK_2       1
`define BIT_FULL_DUPLEX    0

// ****************************************************************
// reset value, shared by every register
// ****************************************************************
`define RST_REG            8'h00

`endif

// ---- inc/dpcfg_pkg.sv ----
// types shared by the config register group and its sample conditioner
// assumes nothing beyond the defines header
package dpcfg_pkg;

   // controls of one clock doubler
   typedef struct packed {
      logic       reset;        // held in reset while set
      logic       duty_type;    // 0 fixed pulse width, 1 fixed duty
      logic [7:0] tuning;       // unlock/lock/offset/hysteresis byte
      logic [2:0] pulse_width;  // pulse width code
   } doubler_ctrl_t;

   // receive routing state
   typedef struct packed {
      logic single;      // one receive path only
      logic conv_i;      // delivered converter, 1 = I
      logic clk_i;       // receive clock, 1 = I side
   } rx_route_t;

   // one signed converter sample
   typedef logic signed [11:0] sample_t;

endpackage

// ---- rtl/sample_condition.sv ----
// sign inversion and optional quarter-step gain for one 12-bit sample
// assumes the caller registers the result
`timescale 1ns/100ps
module sample_condition (
   input  wire dpcfg_pkg::sample_t i_sample,     // raw sample
   input  wire logic               i_negate,     // multiply by -1
   input  wire logic               i_gain_en,    // apply gain
   input  wire logic [4:0]         i_gain,       // gain code, gain = code/4
   output      dpcfg_pkg::sample_t o_sample      // conditioned, saturated
);

   logic signed [12:0] neg_w;   // negated, one bit wider
   logic signed [18:0] prod_w;  // sample times code
   logic signed [16:0] scl_w;   // product over four

   // ****************************************************************
   // negate then scale, saturating at the 12-bit rails
   // ****************************************************************
   always_comb begin
      // widening first keeps -2048 from wrapping back to itself
      neg_w  = i_negate ? -{i_sample[11], i_sample} : {i_sample[11], i_sample};
      prod_w = neg_w * $signed({1'b0, i_gain});
      scl_w  = i_gain_en ? prod_w[18:2] : {{4{neg_w[12]}}, neg_w};
      if (scl_w > 17'sd2047) begin
         o_sample = 12'sh7FF;
      end else if (scl_w < -17'sd2048) begin
         o_sample = 12'sh800;
      end else begin
         o_sample = scl_w[11:0];
      end
   end

endmodule // sample_condition

// ---- rtl/datapath_clock_config_regs.sv ----
// config register group 0x38..0x3F with the datapath effects it steers
// assumes an 8-bit register port on i_clk_sys from the serial control decoder,
// samples on i_clk_sys, and an asynchronous direction pin and doubler clock
`timescale 1ns/100ps
`include "dpcfg_defines.svh"
module datapath_clock_config_regs (
   input  wire logic                     i_clk_sys,        // system clock
   input  wire logic                     i_rst,            // async reset
   input  wire logic                     i_reg_wr,         // write strobe
   input  wire logic                     i_reg_rd,         // read strobe
   input  wire logic [7:0]               i_reg_addr,       // register address
   input  wire logic [7:0]               i_reg_wdata,      // write data
   output      logic [7:0]               o_reg_rdata,      // read data
   output      logic                     o_reg_hit,        // address in group
   input  wire logic                     i_dir_reg_tx,     // serial direction bit
   input  wire logic                     i_dir_pin,        // direction pin, async
   input  wire logic                     i_dll_clk,        // doubler clock, async
   output      logic                     o_bus_dir_tx,     // 1 transmit, 0 receive
   output      logic                     o_full_duplex,    // interface mode
   output      logic                     o_hd_two_clock,   // hd 2-clock submode
   output      logic                     o_txpin_out,      // tx clock pin level
   output      logic                     o_txpin_oe,       // tx clock pin enable
   output      dpcfg_pkg::doubler_ctrl_t o_rx_doubler,     // rx doubler controls
   output      dpcfg_pkg::doubler_ctrl_t o_tx_doubler,     // tx doubler controls
   output      logic [7:0]               o_tap_delay,      // shared initial tap
   output      dpcfg_pkg::rx_route_t     o_rx_route,       // rx routing
   input  wire logic                     i_rx_valid,       // rx sample strobe
   input  wire dpcfg_pkg::sample_t       i_rx_i,           // rx I sample
   input  wire dpcfg_pkg::sample_t       i_rx_q,           // rx Q sample
   output      logic                     o_rx_valid,       // rx out strobe
   output      dpcfg_pkg::sample_t       o_rx_i,           // rx I out
   output      dpcfg_pkg::sample_t       o_rx_q,           // rx Q out
   input  wire logic                     i_tx_valid,       // tx sample strobe
   input  wire dpcfg_pkg::sample_t       i_tx_i,           // tx I sample
   input  wire dpcfg_pkg::sample_t       i_tx_q,           // tx Q sample
   output      logic                     o_tx_valid,       // tx out strobe
   output      dpcfg_pkg::sample_t       o_tx_i,           // tx I out
   output      dpcfg_pkg::sample_t       o_tx_q            // tx Q out
);

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [7:0] gain_q;     // receive_gain
   logic [7:0] rsttype_q;  // doubler_reset_and_type
   logic [7:0] txtune_q;   // transmit_doubler_tuning
   logic [7:0] rxtune_q;   // receive_doubler_tuning
   logic [7:0] tap_q;      // doubler_initial_tap
   logic [7:0] inv_q;      // sample_sign_inversion
   logic [7:0] pw_q;       // doubler_pulse_width
   logic [7:0] rxif_q;     // receive_interface_options
   logic [7:0] rdata_d;    // read mux
   logic       hit_d;      // decode of the group

   // synchronisers and conditioned samples
   logic       pin_s1_q;   // direction pin, first stage
   logic       pin_s2_q;   // direction pin, second stage
   logic       dll_s1_q;   // doubler clock, first stage
   logic       dll_s2_q;   // doubler clock, second stage
   dpcfg_pkg::sample_t rxi_w;  // conditioned rx I
   dpcfg_pkg::sample_t rxq_w;  // conditioned rx Q
   dpcfg_pkg::sample_t txi_w;  // conditioned tx I
   dpcfg_pkg::sample_t txq_w;  // conditioned tx Q
   logic       hd1_w;      // half-duplex 1-clock mode

   // ****************************************************************
   // register writes
   // ****************************************************************
   // unused bits are masked on write so storage never holds them
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         gain_q    <= `RST_REG;
         rsttype_q <= `RST_REG;
         txtune_q  <= `RST_REG;
         rxtune_q  <= `RST_REG;
         tap_q     <= `RST_REG;
         inv_q     <= `RST_REG;
         pw_q      <= `RST_REG;
         rxif_q    <= `RST_REG;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            `OFS_RX_GAIN: begin
               gain_q <= i_reg_wdata & `MASK_RX_GAIN;
            end
            `OFS_DBL_RST_TYPE: begin
               rsttype_q <= i_reg_wdata & `MASK_DBL_RST_TYPE;
            end
            `OFS_TX_DBL_TUNE: begin
               // recommended 01 per field; stored as written
               txtune_q <= i_reg_wdata;
            end
            `OFS_RX_DBL_TUNE: begin
               rxtune_q <= i_reg_wdata;
            end
            `OFS_DBL_TAP: begin
               tap_q <= i_reg_wdata;
            end
            `OFS_SIGN_INV: begin
               inv_q <= i_reg_wdata & `MASK_SIGN_INV;
            end
            `OFS_DBL_PW: begin
               pw_q <= i_reg_wdata & `MASK_DBL_PW;
            end
            `OFS_RX_IF_OPT: begin
               rxif_q <= i_reg_wdata & `MASK_RX_IF_OPT;
            end
            default: begin
               // addresses outside the group are ignored here
            end
         endcase
      end
   end

   // ****************************************************************
   // read decode
   // ****************************************************************
   // storage already holds zeros in unused bits
   always_comb begin
      hit_d   = 1'b1;
      rdata_d = 8'h00;
      unique case (i_reg_addr)
         `OFS_RX_GAIN:      rdata_d = gain_q;
         `OFS_DBL_RST_TYPE: rdata_d = rsttype_q;
         `OFS_TX_DBL_TUNE:  rdata_d = txtune_q;
         `OFS_RX_DBL_TUNE:  rdata_d = rxtune_q;
         `OFS_DBL_TAP:      rdata_d = tap_q;
         `OFS_SIGN_INV:     rdata_d = inv_q;
         `OFS_DBL_PW:       rdata_d = pw_q;
         `OFS_RX_IF_OPT:    rdata_d = rxif_q;
         default: begin
            // other addresses belong to neighbouring groups
            hit_d = 1'b0;
         end
      endcase
   end

   // read data is registered; it stands until the next read
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
         o_reg_hit   <= 1'b0;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rdata_d;
         o_reg_hit   <= hit_d;
      end
   end

   // ****************************************************************
   // doubler controls
   // ****************************************************************
   // straight register fields, so they follow a write by one edge
   always_comb begin
      o_rx_doubler.reset       = rsttype_q[`BIT_RX_DBL_RST];
      o_tx_doubler.reset       = rsttype_q[`BIT_TX_DBL_RST];
      o_rx_doubler.duty_type   = rsttype_q[`BIT_RX_DBL_TYPE];
      o_tx_doubler.duty_type   = rsttype_q[`BIT_TX_DBL_TYPE];
      o_rx_doubler.tuning      = rxtune_q;
      o_tx_doubler.tuning      = txtune_q;
      o_tx_doubler.pulse_width = pw_q[5:3];
      o_rx_doubler.pulse_width = pw_q[2:0];
      o_tap_delay              = tap_q;
   end

   // ****************************************************************
   // receive routing
   // ****************************************************************
   always_comb begin
      o_rx_route.single = rxif_q[`BIT_SINGLE_RX];
      o_rx_route.conv_i = rxif_q[`BIT_RX_BUS_I];
      o_rx_route.clk_i  = rxif_q[`BIT_RX_CLK_I];
   end

   // ****************************************************************
   // interface mode outputs
   // ****************************************************************
   always_comb begin
      o_full_duplex  = rxif_q[`BIT_FULL_DUPLEX];
      o_hd_two_clock = rxif_q[`BIT_HD_CLK_2];
   end

   // 1-clock submode exists only when half-duplex is selected
   assign hd1_w = ~rxif_q[`BIT_FULL_DUPLEX] & ~rxif_q[`BIT_HD_CLK_2];

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // second stage alone is read; the first may go metastable
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= i_dir_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // the doubler clock is only sampled, so it reaches the pin
   // coarsely; fine for slow rates, a true clock path is needed above
   // a quarter of the system rate
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         dll_s1_q <= 1'b0;
         dll_s2_q <= 1'b0;
      end else begin
         dll_s1_q <= i_dll_clk;
         dll_s2_q <= dll_s1_q;
      end
   end

   // ****************************************************************
   // bus direction
   // ****************************************************************
   // full duplex has no direction; it reports transmit there
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_bus_dir_tx <= 1'b0;
      end else if (rxif_q[`BIT_FULL_DUPLEX]) begin
         o_bus_dir_tx <= 1'b1;
      end else if (rxif_q[`BIT_HD_DIR_PIN]) begin
         o_bus_dir_tx <= pin_s2_q;
      end else begin
         o_bus_dir_tx <= i_dir_reg_tx;
      end
   end

   // ****************************************************************
   // tx clock pin
   // ****************************************************************
   // outside hd 1-clock mode the pin is left to its mode logic: off
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_txpin_oe  <= 1'b0;
         o_txpin_out <= 1'b0;
      end else begin
         o_txpin_oe  <= hd1_w & rxif_q[`BIT_TXPIN_DRIVE];
         o_txpin_out <= hd1_w & rxif_q[`BIT_TXPIN_DRIVE] & dll_s2_q;
      end
   end

   // ****************************************************************
   // sample conditioning
   // ****************************************************************
   sample_condition u_rx_i (
      .i_sample  (i_rx_i),
      .i_negate  (inv_q[`BIT_RX_I_NEG]),
      .i_gain_en (1'b1),
      .i_gain    (gain_q[4:0]),
      .o_sample  (rxi_w)
   );

   sample_condition u_rx_q (
      .i_sample  (i_rx_q),
      .i_negate  (inv_q[`BIT_RX_Q_NEG]),
      .i_gain_en (1'b1),
      .i_gain    (gain_q[4:0]),
      .o_sample  (rxq_w)
   );

   sample_condition u_tx_i (
      .i_sample  (i_tx_i),
      .i_negate  (inv_q[`BIT_TX_I_NEG]),
      .i_gain_en (1'b0),
      .i_gain    (5'h00),
      .o_sample  (txi_w)
   );

   sample_condition u_tx_q (
      .i_sample  (i_tx_q),
      .i_negate  (inv_q[`BIT_TX_Q_NEG]),
      .i_gain_en (1'b0),
      .i_gain    (5'h00),
      .o_sample  (txq_w)
   );

   // ****************************************************************
   // receive output stage
   // ****************************************************************
   // in single path the chosen converter leaves on the I lane, Q is 0
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rx_valid <= 1'b0;
         o_rx_i     <= 12'h000;
         o_rx_q     <= 12'h000;
      end else begin
         o_rx_valid <= i_rx_valid;
         if (i_rx_valid) begin
            if (rxif_q[`BIT_SINGLE_RX]) begin
               o_rx_i <= rxif_q[`BIT_RX_BUS_I] ? rxi_w : rxq_w;
               o_rx_q <= 12'h000;
            end else begin
               o_rx_i <= rxi_w;
               o_rx_q <= rxq_w;
            end
         end
      end
   end

   // ****************************************************************
   // transmit output stage
   // ****************************************************************
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_tx_valid <= 1'b0;
         o_tx_i     <= 12'h000;
         o_tx_q     <= 12'h000;
      end else begin
         o_tx_valid <= i_tx_valid;
         if (i_tx_valid) begin
            o_tx_i <= txi_w;
            o_tx_q <= txq_w;
         end
      end
   end

endmodule // datapath_clock_config_regs

// ---- test/dpcfg_props.sv ----
// concurrent checks on the ports of the datapath and doubler config group
// assumes one clock domain, i_clk_sys, with i_rst asynchronous and active high
`timescale 1ns/100ps
module dpcfg_props (
   input wire logic                     i_clk_sys,      // system clock
   input wire logic                     i_rst,          // async reset
   input wire logic                     i_reg_wr,       // write strobe
   input wire logic                     i_reg_rd,       // read strobe
   input wire logic [7:0]               i_reg_addr,     // register address
   input wire logic [7:0]               o_reg_rdata,    // read data
   input wire logic                     o_reg_hit,      // group hit
   input wire logic                     o_bus_dir_tx,   // bus direction
   input wire logic                     o_full_duplex,  // interface mode
   input wire logic                     o_hd_two_clock, // hd submode
   input wire logic                     o_txpin_out,    // tx clock level
   input wire logic                     o_txpin_oe,     // tx clock enable
   input wire dpcfg_pkg::doubler_ctrl_t o_rx_doubler,   // rx doubler
   input wire dpcfg_pkg::doubler_ctrl_t o_tx_doubler,   // tx doubler
   input wire logic [7:0]               o_tap_delay,    // shared tap
   input wire dpcfg_pkg::rx_route_t     o_rx_route,     // rx routing
   input wire logic                     i_rx_valid,     // rx strobe in
   input wire logic                     o_rx_valid,     // rx strobe out
   input wire dpcfg_pkg::sample_t       o_rx_i,         // rx I out
   input wire dpcfg_pkg::sample_t       o_rx_q,         // rx Q out
   input wire logic                     i_tx_valid,     // tx strobe in
   input wire logic                     o_tx_valid      // tx strobe out
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // a read inside or outside the group
   sequence s_rd_miss;
      i_reg_rd && (i_reg_addr < 8'h38 || i_reg_addr > 8'h3F);
   endsequence
   sequence s_rd_hit;
      i_reg_rd && i_reg_addr >= 8'h38 && i_reg_addr <= 8'h3F;
   endsequence
   chk_rd_miss_zero: assert property (
      s_rd_miss |=> !o_reg_hit && o_reg_rdata == 8'h00)
      else $error("unmapped read gave data");
   chk_rd_hit_flag: assert property (s_rd_hit |=> o_reg_hit)
      else $error("group read without hit");
   chk_rx_lag: assert property (i_rx_valid |=> o_rx_valid)
      else $error("rx strobe lost");
   chk_rx_hold: assert property (
      !i_rx_valid |=> !o_rx_valid && $stable(o_rx_i) && $stable(o_rx_q))
      else $error("rx output moved without strobe");
   chk_tx_lag: assert property (o_tx_valid == $past(i_tx_valid))
      else $error("tx strobe lag wrong");
   // outputs move only after a write to their own register
   chk_route_cause: assert property (
      $changed(o_rx_route) |-> $past(i_reg_wr && i_reg_addr == 8'h3F))
      else $error("routing moved without write");
   chk_tap_cause: assert property (
      $changed(o_tap_delay) |-> $past(i_reg_wr && i_reg_addr == 8'h3C))
      else $error("tap delay moved without write");
   chk_dbl_rst_cause: assert property (
      $changed({o_rx_doubler.reset, o_tx_doubler.reset})
      |-> $past(i_reg_wr && i_reg_addr == 8'h39))
      else $error("doubler reset moved without write");
   chk_txpin_quiet: assert property (!o_txpin_oe |-> !o_txpin_out)
      else $error("tx clock driven while disabled");
   // a mode held two cycles leaves time for the registered derivations
   chk_txpin_mode: assert property (
      (o_full_duplex && $past(o_full_duplex)) || (o_hd_two_clock && $past(o_hd_two_clock))
      |-> !o_txpin_oe)
      else $error("tx clock enabled outside hd 1-clock");
   chk_fd_dir: assert property (
      o_full_duplex && $past(o_full_duplex) |-> o_bus_dir_tx)
      else $error("full duplex direction not transmit");
endmodule // dpcfg_props

bind datapath_clock_config_regs dpcfg_props i_dpcfg_props (.i_clk_sys, .i_rst, .i_reg_wr,
   .i_reg_rd, .i_reg_addr, .o_reg_rdata, .o_reg_hit, .o_bus_dir_tx, .o_full_duplex,
   .o_hd_two_clock, .o_txpin_out, .o_txpin_oe, .o_rx_doubler, .o_tx_doubler, .o_tap_delay,
   .o_rx_route, .i_rx_valid, .o_rx_valid, .o_rx_i, .o_rx_q, .i_tx_valid, .o_tx_valid);

// ---- test/tb_top.sv ----
// self-checking bench for the datapath and doubler config group
// assumes the checker file binds itself; all inputs driven on the rising edge
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
   // ****************************************************************
   // stimulus and observed signals
   // ****************************************************************
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_dir_reg_tx = 1'b0, i_dir_pin = 1'b0, i_dll_clk = 1'b0;
   logic i_rx_valid = 1'b0, i_tx_valid = 1'b0;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_tap_delay;
   logic o_reg_hit, o_bus_dir_tx, o_full_duplex, o_hd_two_clock, o_txpin_out, o_txpin_oe;
   logic o_rx_valid, o_tx_valid;
   dpcfg_pkg::doubler_ctrl_t o_rx_doubler, o_tx_doubler;
   dpcfg_pkg::rx_route_t     o_rx_route;
   dpcfg_pkg::sample_t i_rx_i = 12'h000, i_rx_q = 12'h000, i_tx_i = 12'h000, i_tx_q = 12'h000;
   dpcfg_pkg::sample_t o_rx_i, o_rx_q, o_tx_i, o_tx_q;
   int err_count = 0, num_checks = 0, cyc = 0;
   datapath_clock_config_regs i_datapath_clock_config_regs (.i_clk_sys, .i_rst, .i_reg_wr,
      .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .i_dir_reg_tx,
      .i_dir_pin, .i_dll_clk, .o_bus_dir_tx, .o_full_duplex, .o_hd_two_clock, .o_txpin_out,
      .o_txpin_oe, .o_rx_doubler, .o_tx_doubler, .o_tap_delay, .o_rx_route, .i_rx_valid,
      .i_rx_i, .i_rx_q, .o_rx_valid, .o_rx_i, .o_rx_q, .i_tx_valid, .i_tx_i, .i_tx_q,
      .o_tx_valid, .o_tx_i, .o_tx_q);
   always #4 i_clk_sys = ~i_clk_sys; // 125 MHz
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      tick(1);
      `CHK("rdata", e, o_reg_rdata)
      `CHK("hit", h, o_reg_hit)
   endtask
   // one strobe on both paths, judged one cycle later
   task automatic smp(input int ri, rq, ti, tq, input logic [11:0] eri, erq, eti, etq);
      @(posedge i_clk_sys);
      {i_rx_valid, i_tx_valid} <= 2'b11;
      {i_rx_i, i_rx_q, i_tx_i, i_tx_q} <= {12'(ri), 12'(rq), 12'(ti), 12'(tq)};
      @(posedge i_clk_sys);
      {i_rx_valid, i_tx_valid} <= 2'b00;
      tick(1);
      `CHK("valid", 2'b11, {o_rx_valid, o_tx_valid})
      `CHK("rx", {eri, erq}, {o_rx_i, o_rx_q})
      `CHK("tx", {eti, etq}, {o_tx_i, o_tx_q})
   endtask
   // expected receive sample: negate, times code, floor of a quarter, clamp
   function automatic logic [11:0] rxm(input int x, input bit n, input int c);
      int v;
      v = ((n ? -x : x) * c) >>> 2;
      if (v > 2047) v = 2047;
      if (v < -2048) v = -2048;
      return v[11:0];
   endfunction
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      logic [7:0] m [8] = '{8'h1F, 8'hC3, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h7F};
      for (int k = 0; k < 8; k++) begin
         rd_reg(8'h38 + k[7:0], 8'h00, 1'b1);
         wr_reg(8'h38 + k[7:0], 8'hFF);
         rd_reg(8'h38 + k[7:0], m[k], 1'b1);
         wr_reg(8'h38 + k[7:0], 8'h00);
      end
      wr_reg(8'h40, 8'hFF);
      rd_reg(8'h37, 8'h00, 1'b0);
      rd_reg(8'h40, 8'h00, 1'b0);
   endtask
   task automatic t_dbl();
      wr_reg(8'h39, 8'h81);
      wr_reg(8'h3A, 8'h55);
      wr_reg(8'h3B, 8'hAA);
      wr_reg(8'h3C, 8'h5A);
      wr_reg(8'h3E, 8'h2B);
      tick(1);
      `CHK("rxdbl", {2'b10, 8'hAA, 3'h3}, o_rx_doubler)
      `CHK("txdbl", {2'b01, 8'h55, 3'h5}, o_tx_doubler)
      `CHK("tap", 8'h5A, o_tap_delay)
      wr_reg(8'h39, 8'h42);
      tick(1);
      `CHK("types", 4'b0110, {o_rx_doubler[12:11], o_tx_doubler[12:11]})
      wr_reg(8'h3B, 8'h55);
      tick(1);
      `CHK("rxtune", 8'h55, o_rx_doubler.tuning)
   endtask
   task automatic t_rx();
      int c [5][4] = '{'{4, 0, 100, -100}, '{1, 12, 7, -7}, '{31, 0, 1000, -1000},
                       '{0, 12, 500, -9}, '{4, 4, -50, 50}};
      for (int k = 0; k < 5; k++) begin
         wr_reg(8'h38, 8'(c[k][0]));
         wr_reg(8'h3D, 8'(c[k][1]));
         smp(c[k][2], c[k][3], 0, 0, rxm(c[k][2], c[k][1][2], c[k][0]),
             rxm(c[k][3], c[k][1][3], c[k][0]), 12'h000, 12'h000);
      end
   endtask
   task automatic t_tx();
      wr_reg(8'h38, 8'h1F);
      wr_reg(8'h3D, 8'h01);
      smp(0, 0, -2048, 5, 12'h000, 12'h000, 12'h7FF, 12'h005);
      wr_reg(8'h3D, 8'h02);
      smp(0, 0, -3, -3, 12'h000, 12'h000, 12'hFFD, 12'h003);
   endtask
   task automatic t_single();
      wr_reg(8'h38, 8'h04);
      wr_reg(8'h3D, 8'h00);
      wr_reg(8'h3F, 8'h10);
      smp(100, -30, 0, 0, 12'hFE2, 12'h000, 12'h000, 12'h000);
      `CHK("route", 3'b100, o_rx_route)
      wr_reg(8'h3F, 8'h70);
      smp(100, -30, 0, 0, 12'h064, 12'h000, 12'h000, 12'h000);
      `CHK("route", 3'b111, o_rx_route)
   endtask
   task automatic t_dir();
      wr_reg(8'h3F, 8'h00);
      @(posedge i_clk_sys) i_dir_reg_tx <= 1'b1;
      tick(3);
      `CHK("dirreg", 1'b1, o_bus_dir_tx)
      wr_reg(8'h3F, 8'h04);
      tick(5);
      `CHK("dirpin0", 1'b0, o_bus_dir_tx)
      @(posedge i_clk_sys) i_dir_pin <= 1'b1;
      tick(5);
      `CHK("dirpin1", 1'b1, o_bus_dir_tx)
      wr_reg(8'h3F, 8'h09);
      @(posedge i_clk_sys) i_dll_clk <= 1'b1;
      tick(5);
      `CHK("fdoe", 3'b110, {o_full_duplex, o_bus_dir_tx, o_txpin_oe})
      wr_reg(8'h3F, 8'h08);
      tick(5);
      `CHK("hd1clk", 2'b11, {o_txpin_oe, o_txpin_out})
      @(posedge i_clk_sys) i_dll_clk <= 1'b0;
      tick(5);
      `CHK("hd1low", 2'b10, {o_txpin_oe, o_txpin_out})
      wr_reg(8'h3F, 8'h0A);
      tick(3);
      `CHK("hd2", 2'b10, {o_hd_two_clock, o_txpin_oe})
      @(posedge i_clk_sys) i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd_reg(8'h3F, 8'h00, 1'b1);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_regs();
      t_dbl();
      t_rx();
      t_tx();
      t_single();
      t_dir();
      test_done();
   end
endmodule // tb_top
